// ### verilog/tmi_target.sv
// Two-wire bus target for the touch and key controllers of the module
`timescale 1ns/1ps
module tmi_target
	import tmi_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       touch_addr_sel,
	input  wire logic       touch_event,
	input  wire logic       key_event,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            rd_req,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	output logic            xfer_start,
	output logic            xfer_read,
	output logic            xfer_target,
	output logic            bus_busy,
	output logic            touch_change_irq_n,
	output logic            key_change_irq_n
);

	tmi_state_e state;
	logic       scl_s;
	logic       sda_s;
	logic       strap_s;
	logic       scl_q;
	logic       sda_q;
	logic       strap;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic       want_low;
	logic       have_byte;
	logic       ack_ok;
	logic [5:0] hold_cnt;
	logic [5:0] setup_cnt;
	logic [6:0] touch_addr;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic       fetch_take;
	logic       setup_done;
	logic       hit_touch;
	logic       hit_key;

	tmi_sync #(.RESET_VAL(LINE_IDLE)) u_scl_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.d       (scl_in),
		.q       (scl_s)
	);

	tmi_sync #(.RESET_VAL(LINE_IDLE)) u_sda_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.d       (sda_in),
		.q       (sda_s)
	);

	tmi_sync #(.RESET_VAL(STRAP_RESET)) u_strap_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.d       (touch_addr_sel),
		.q       (strap_s)
	);

	// Open-drain: the driven level is always low, only the enables move
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_q <= LINE_IDLE;
			sda_q <= LINE_IDLE;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_q;
	assign scl_fall  = ~scl_s & scl_q;
	// Data moving while clock is high can only be start or stop
	assign start_det = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_busy <= 1'b0;
		end else if (start_det) begin
			bus_busy <= 1'b1;
		end else if (stop_det) begin
			bus_busy <= 1'b0;
		end
	end

	// Strap is only taken while the bus is free, so an address never changes mid-transfer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			strap <= STRAP_RESET;
		end else if (!bus_busy) begin
			strap <= strap_s;
		end
	end

	assign touch_addr = strap ? TOUCH_ADDR_ALT : TOUCH_ADDR_DEFAULT;
	assign hit_touch  = (shreg[7:1] == touch_addr);
	assign hit_key    = (shreg[7:1] == KEY_ADDR);

	// Next read byte is taken only after the hold time of the last edge
	assign fetch_take = (state == ST_RD_FETCH) && tx_valid && !have_byte && (hold_cnt == 6'h00);
	assign setup_done = (state == ST_RD_FETCH) && have_byte && (setup_cnt == 6'h01);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state       <= ST_IDLE;
			bit_cnt     <= 4'h0;
			shreg       <= 8'h00;
			want_low    <= 1'b0;
			have_byte   <= 1'b0;
			ack_ok      <= 1'b0;
			rd_req      <= 1'b0;
			rx_valid    <= 1'b0;
			rx_data     <= 8'h00;
			xfer_start  <= 1'b0;
			xfer_read   <= 1'b0;
			xfer_target <= TARGET_TOUCH;
		end else begin
			rd_req     <= 1'b0;
			rx_valid   <= 1'b0;
			xfer_start <= 1'b0;
			if (start_det) begin
				state     <= ST_ADDR;
				bit_cnt   <= 4'h0;
				want_low  <= 1'b0;
				have_byte <= 1'b0;
			end else if (stop_det) begin
				state     <= ST_IDLE;
				want_low  <= 1'b0;
				have_byte <= 1'b0;
			end else begin
				unique case (state)
					ST_IDLE, ST_IGNORE: begin
						want_low <= 1'b0;
					end
					ST_ADDR: begin
						if (scl_rise) begin
							shreg   <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
							if (hit_touch || hit_key) begin
								state       <= ST_ADDR_ACK;
								want_low    <= 1'b1;
								xfer_start  <= 1'b1;
								xfer_read   <= shreg[0];
								xfer_target <= hit_key ? TARGET_KEY : TARGET_TOUCH;
							end else begin
								state    <= ST_IGNORE;
								want_low <= 1'b0;
							end
						end
					end
					ST_ADDR_ACK: begin
						if (scl_fall) begin
							want_low <= 1'b0;
							bit_cnt  <= 4'h0;
							if (xfer_read) begin
								state     <= ST_RD_FETCH;
								rd_req    <= 1'b1;
								have_byte <= 1'b0;
							end else begin
								state <= ST_WR_BYTE;
							end
						end
					end
					ST_WR_BYTE: begin
						if (scl_rise) begin
							shreg   <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
							state    <= ST_WR_ACK;
							want_low <= 1'b1;
							rx_data  <= shreg;
							rx_valid <= 1'b1;
						end
					end
					ST_WR_ACK: begin
						if (scl_fall) begin
							state    <= ST_WR_BYTE;
							want_low <= 1'b0;
							bit_cnt  <= 4'h0;
						end
					end
					ST_RD_FETCH: begin
						if (fetch_take) begin
							shreg     <= tx_data;
							want_low  <= ~tx_data[7];
							have_byte <= 1'b1;
						end else if (setup_done) begin
							state     <= ST_RD_BYTE;
							have_byte <= 1'b0;
							bit_cnt   <= 4'h0;
						end
					end
					ST_RD_BYTE: begin
						if (scl_rise) begin
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall) begin
							if (bit_cnt == BITS_PER_BYTE) begin
								state    <= ST_RD_ACK;
								want_low <= 1'b0;
							end else begin
								shreg    <= {shreg[6:0], 1'b0};
								want_low <= ~shreg[6];
							end
						end
					end
					ST_RD_ACK: begin
						if (scl_rise) begin
							ack_ok <= ~sda_s;
						end else if (scl_fall) begin
							if (ack_ok) begin
								state     <= ST_RD_FETCH;
								rd_req    <= 1'b1;
								have_byte <= 1'b0;
							end else begin
								state <= ST_IGNORE;
							end
						end
					end
				endcase
			end
		end
	end

	// Data changes only a hold time after the clock falls, never while it is high
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hold_cnt <= 6'h00;
		end else if (start_det || stop_det) begin
			hold_cnt <= 6'h00;
		end else if (scl_fall) begin
			hold_cnt <= HOLD_CYC;
		end else if (hold_cnt != 6'h00) begin
			hold_cnt <= hold_cnt - 6'h01;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sda_oe <= 1'b0;
		end else if (start_det || stop_det) begin
			sda_oe <= 1'b0;
		end else if (hold_cnt == 6'h01) begin
			sda_oe <= want_low;
		end else if (fetch_take) begin
			sda_oe <= ~tx_data[7];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			setup_cnt <= 6'h00;
		end else if (state != ST_RD_FETCH) begin
			setup_cnt <= 6'h00;
		end else if (fetch_take) begin
			setup_cnt <= SETUP_CYC;
		end else if (setup_cnt != 6'h00) begin
			setup_cnt <= setup_cnt - 6'h01;
		end
	end

	// Clock held low until the next read byte has been on the data line for the setup time; the host never sees a
	// short high phase because the clock is already low when the hold begins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_oe <= 1'b0;
		end else begin
			scl_oe <= (state == ST_RD_FETCH) && !setup_done && !start_det && !stop_det;
		end
	end

	tmi_chg u_touch_chg (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.set_evt  (touch_event),
		.clr_evt  (xfer_start && xfer_read && (xfer_target == TARGET_TOUCH)),
		.change_n (touch_change_irq_n)
	);

	tmi_chg u_key_chg (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.set_evt  (key_event),
		.clr_evt  (xfer_start && xfer_read && (xfer_target == TARGET_KEY)),
		.change_n (key_change_irq_n)
	);

endmodule // tmi_target

// ### verilog/tmi_pkg.sv
// Constants and state type for the touch module two-wire target
package tmi_pkg;

	localparam int CLK_MHZ      = 125;
	localparam int BUS_MAX_KHZ  = 400;
	localparam int DATA_HOLD_NS = 300;
	localparam int DATA_SETUP_NS = 250;

	// Least times, rounded up to whole clock cycles
	localparam logic [5:0] HOLD_CYC  = 6'((DATA_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [5:0] SETUP_CYC = 6'((DATA_SETUP_NS * CLK_MHZ + 999) / 1000);

	localparam logic [6:0] TOUCH_ADDR_DEFAULT = 7'h4a;
	localparam logic [6:0] TOUCH_ADDR_ALT     = 7'h4b;
	localparam logic [6:0] KEY_ADDR           = 7'h1b;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic       LINE_IDLE     = 1'b1;
	localparam logic       STRAP_RESET   = 1'b0;
	localparam logic       TARGET_TOUCH  = 1'b0;
	localparam logic       TARGET_KEY    = 1'b1;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR_BYTE,
		ST_WR_ACK,
		ST_RD_FETCH,
		ST_RD_BYTE,
		ST_RD_ACK,
		ST_IGNORE
	} tmi_state_e;

endpackage

// ### verilog/tmi_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module tmi_sync
	import tmi_pkg::*;
#(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic d,
	output logic      q
);

	logic s1;
	logic s2;
	logic s3;

	// Output moves only when the second and third stages agree
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
			q  <= RESET_VAL;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				q <= s3;
			end
		end
	end

endmodule // tmi_sync

// ### verilog/tmi_chg.sv
// Active-low change line for one controller
`timescale 1ns/1ps
module tmi_chg
	import tmi_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic set_evt,
	input  wire logic clr_evt,
	output logic      change_n
);

	// A new event in the clearing cycle keeps the line low
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			change_n <= 1'b1;
		end else if (set_evt) begin
			change_n <= 1'b0;
		end else if (clr_evt) begin
			change_n <= 1'b1;
		end
	end

endmodule // tmi_chg

// ### tb/tmi_target_asserts.sv
// Bus-level checks bound to the two-wire target
`timescale 1ns/1ps
module tmi_target_asserts (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic scl_out,
	input wire logic sda_out,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic rd_req,
	input wire logic rx_valid,
	input wire logic xfer_start,
	input wire logic xfer_read,
	input wire logic bus_busy,
	input wire logic touch_event,
	input wire logic key_event,
	input wire logic touch_change_irq_n,
	input wire logic key_change_irq_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_od; !scl_out && !sda_out; endproperty
	a_od: assert property (p_od) else $error("line driven high");
	property p_stable; $changed(sda_oe) |-> !scl_in; endproperty
	a_stable: assert property (p_stable) else $error("data moved, clock high");
	property p_busy_on; $fell(sda_in) && scl_in |-> ##[1:6] bus_busy; endproperty
	a_busy_on: assert property (p_busy_on) else $error("busy not set");
	property p_busy_off; $rose(sda_in) && scl_in |-> ##[1:6] !bus_busy; endproperty
	a_busy_off: assert property (p_busy_off) else $error("busy not cleared");
	property p_ack_adr; xfer_start |-> ##[36:42] sda_oe; endproperty
	a_ack_adr: assert property (p_ack_adr) else $error("no address ack");
	property p_ack_wr; rx_valid |-> ##[36:42] sda_oe; endproperty
	a_ack_wr: assert property (p_ack_wr) else $error("no data ack");
	property p_stretch; rd_req |=> scl_oe; endproperty
	a_stretch: assert property (p_stretch) else $error("no stretch");
	property p_rd_only; scl_oe |-> xfer_read; endproperty
	a_rd_only: assert property (p_rd_only) else $error("stretch on write");
	property p_tchg; touch_event |=> !touch_change_irq_n; endproperty
	a_tchg: assert property (p_tchg) else $error("touch line high");
	property p_kchg; key_event |=> !key_change_irq_n; endproperty
	a_kchg: assert property (p_kchg) else $error("key line high");
	c_rd: cover property (xfer_start && xfer_read);
	c_rel: cover property ($fell(scl_oe));
	c_wr: cover property (rx_valid);
endmodule // tmi_target_asserts

bind tmi_target tmi_target_asserts chk_u (.sys_clk(sys_clk), .rst(rst), .scl_in(scl_in),
	.sda_in(sda_in), .scl_out(scl_out), .sda_out(sda_out), .scl_oe(scl_oe), .sda_oe(sda_oe),
	.rd_req(rd_req), .rx_valid(rx_valid), .xfer_start(xfer_start), .xfer_read(xfer_read),
	.bus_busy(bus_busy), .touch_event(touch_event), .key_event(key_event),
	.touch_change_irq_n(touch_change_irq_n), .key_change_irq_n(key_change_irq_n));

// ### tb/tmi_host.sv
// Behavioural bus controller driving the target's lines
`timescale 1ns/1ps
module tmi_host #(
	parameter int Q = 79
) (
	input  wire logic sys_clk,
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	output logic      scl_in,
	output logic      sda_in
);
	logic scl_lo = 1'b0;
	logic sda_lo = 1'b0;
	int   wt;
	int   stalls = 0;
	// Pull-ups on both lines; any party low wins
	assign scl_in = !(scl_lo || scl_oe);
	assign sda_in = !(sda_lo || sda_oe);
	task automatic qw(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Four quarters of 79 cycles keep the bit just below 400 kHz; 78 would be too fast
	task automatic rel_clk;
		scl_lo = 1'b0;
		wt = 0;
		while (!scl_in && wt < 5000) begin
			qw(1);
			wt++;
		end
		// A clock that never comes back counts against the run
		if (!scl_in) begin
			stalls++;
		end
	endtask
	task automatic start;
		qw(2 * Q);
		sda_lo = 1'b1;
		qw(Q);
		scl_lo = 1'b1;
	endtask
	task automatic stop;
		qw(Q);
		sda_lo = 1'b1;
		qw(Q);
		rel_clk();
		qw(Q);
		sda_lo = 1'b0;
		qw(2 * Q);
	endtask
	// Repeated start: entered with the clock low, bus stays busy
	task automatic restart;
		qw(Q);
		sda_lo = 1'b0;
		qw(Q);
		rel_clk();
		qw(Q);
		sda_lo = 1'b1;
		qw(Q);
		scl_lo = 1'b1;
	endtask
	task automatic bit_io(input logic b, output logic r);
		qw(Q);
		sda_lo = !b;
		qw(Q);
		rel_clk();
		qw(Q);
		r = sda_in;
		qw(Q);
		scl_lo = 1'b1;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r,
			output logic ak);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(a, ak);
	endtask
endmodule // tmi_host

// ### tb/touch_module_i2c_target_test.sv
// Random and corner transactions against the two-wire target
`timescale 1ns/1ps
module touch_module_i2c_target_test;
	import tmi_pkg::*;
	logic       sys_clk;
	logic       rst;
	logic       touch_addr_sel;
	logic       touch_event;
	logic       key_event;
	logic       tx_valid;
	logic [7:0] tx_data;
	logic [7:0] tx_last;
	logic [7:0] rx_got = 8'h00;
	logic       chain = 1'b0;
	logic       linked = 1'b0;
	logic [7:0] rx_data;
	wire        scl_in, sda_in, scl_oe, sda_oe, rd_req, rx_valid;
	wire        xfer_read, xfer_target, bus_busy, touch_change_irq_n, key_change_irq_n;
	int         rx_cnt = 0;
	int         err_total = 0;
	int         comparisons = 0;
	int         seed = 32'h2d9a;

	tmi_target dut_u (.sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .scl_out(),
		.scl_oe(scl_oe), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe),
		.touch_addr_sel(touch_addr_sel), .touch_event(touch_event), .key_event(key_event),
		.tx_data(tx_data), .tx_valid(tx_valid), .rd_req(rd_req), .rx_data(rx_data),
		.rx_valid(rx_valid), .xfer_start(), .xfer_read(xfer_read),
		.xfer_target(xfer_target), .bus_busy(bus_busy),
		.touch_change_irq_n(touch_change_irq_n), .key_change_irq_n(key_change_irq_n));
	tmi_host host_u (.sys_clk(sys_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
		.scl_in(scl_in), .sda_in(sda_in));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (rx_valid === 1'b1) begin
			rx_got <= rx_data;
			rx_cnt <= rx_cnt + 1;
		end
	end
	// Read bytes come after a random delay, so stretching is exercised
	initial forever begin
		@(negedge sys_clk);
		if (rd_req === 1'b1) begin
			@(negedge sys_clk);
			repeat ({$random(seed)} % 100) @(negedge sys_clk);
			tx_last = 8'($random(seed));
			tx_data = tx_last;
			tx_valid = 1'b1;
			while (scl_oe !== 1'b0) @(negedge sys_clk);
			tx_valid = 1'b0;
		end
	end

	function automatic logic matchf(input logic [6:0] a, input logic sel);
		return a == (sel ? TOUCH_ADDR_ALT : TOUCH_ADDR_DEFAULT) || a == KEY_ADDR;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		err_total += host_u.stalls;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic xact(input logic [6:0] a, input logic rd, input int n);
		logic       m;
		logic       ak;
		logic [7:0] r;
		logic [7:0] d;
		int         c0;
		m = matchf(a, touch_addr_sel);
		if (linked) begin
			host_u.restart();
		end else begin
			host_u.start();
		end
		chk(bus_busy, 1'b1);
		host_u.byte_io({a, rd}, 1'b1, r, ak);
		chk(ak, !m);
		if (m) chk({xfer_read, xfer_target}, {rd, a == KEY_ADDR});
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			c0 = rx_cnt;
			host_u.byte_io(rd ? 8'hff : d, rd ? i == n - 1 : 1'b1, r, ak);
			if (rd) chk(r, m ? tx_last : 8'hff);
			else begin
				chk(ak, !m);
				chk(8'(rx_cnt - c0), 8'(m));
				if (m) chk(rx_got, d);
			end
		end
		linked = chain;
		if (!chain) begin
			host_u.stop();
			chk(bus_busy, 1'b0);
		end
	endtask

	initial begin
		repeat (98000) @(posedge sys_clk);
		err_total++;
		close_out();
	end
	initial begin
		rst = 1'b1;
		touch_addr_sel = STRAP_RESET;
		touch_event = 1'b0;
		key_event = 1'b0;
		tx_data = 8'h00;
		tx_valid = 1'b0;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		repeat (6) @(negedge sys_clk);
		touch_event = 1'b1;
		key_event = 1'b1;
		@(negedge sys_clk);
		touch_event = 1'b0;
		key_event = 1'b0;
		@(negedge sys_clk);
		chk({touch_change_irq_n, key_change_irq_n}, 2'b00);
		xact(7'h4a, 1'b0, 2);
		xact(7'h4b, 1'b0, 1);
		xact(KEY_ADDR, 1'b1, 2);
		chk({touch_change_irq_n, key_change_irq_n}, 2'b01);
		touch_addr_sel = 1'b1;
		xact(7'h4b, 1'b1, 1);
		chk(touch_change_irq_n, 1'b1);
		xact(7'h4a, 1'b1, 1);
		xact(KEY_ADDR, 1'b0, 2);
		chain = 1'b1;
		xact(7'h4b, 1'b0, 1);
		chain = 1'b0;
		xact(KEY_ADDR, 1'b1, 1);
		repeat (2) xact(7'($random(seed)), 1'($random(seed)), 1);
		close_out();
	end
endmodule // touch_module_i2c_target_test
